// ### stb_params.svh
// Offsets, field positions, reset values and timing counts of the scram bypass interlock
`ifndef STB_PARAMS_SVH
`define STB_PARAMS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define STB_CLK_HZ 64'd100000000
`define STB_SD_DELAY_S 64'd10
`define STB_SD_DELAY_CYCLES (`STB_SD_DELAY_S * `STB_CLK_HZ)
`define STB_TBV_LIMIT_US 64'd200
`define STB_TBV_LIMIT_CYCLES ((`STB_TBV_LIMIT_US * `STB_CLK_HZ) / 64'd1000000)

// ****************************************
// Widths
// ****************************************
`define STB_DIV_NUM 4
`define STB_TBV_NUM 8
`define STB_PWR_W 8
`define STB_PRS_W 12

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define STB_OFS_POWER_SP 8'h00
`define STB_OFS_PRESSURE_SP 8'h04
`define STB_OFS_TBV_LIMIT 8'h08
`define STB_OFS_VALVE_CFG 8'h0c
`define STB_OFS_INDICATION 8'h10
`define STB_OFS_ALARM 8'h14

// ****************************************
// Reset values and fields
// ****************************************
`define STB_RST_POWER_SP 8'h28
`define STB_RST_PRESSURE_SP 12'h100
`define STB_RST_CNT_LO 4'h2
`define STB_RST_CNT_HI 4'h6
`define STB_RST_CNT_SPLIT 8'h46
`define STB_CFG_LO_LSB 0
`define STB_CFG_HI_LSB 4
`define STB_CFG_SPLIT_LSB 8

`endif

// ### stb_pkg.sv
// Types shared by the scram bypass interlock
package stb_pkg;

    typedef enum logic [1:0] {
        STB_MODE_SHUTDOWN = 2'b00,
        STB_MODE_REFUEL = 2'b01,
        STB_MODE_STARTUP = 2'b10,
        STB_MODE_RUN = 2'b11
    } stb_mode_t;

    typedef enum logic [1:0] {
        STB_SD_IDLE = 2'b00,
        STB_SD_SCRAM = 2'b01,
        STB_SD_BYPASS = 2'b10
    } stb_sd_state_t;

endpackage : stb_pkg

// ### stb_scram_bypass.sv
// Operational bypass interlock for scram trip functions, four divisions
//
// Summary of operation
// [R1] Stop and control valve closure trips bypassed while power below 40% setpoint.
// [R2] Same trips bypassed if enough bypass valves open within time limit after closure.
// [R3] Low power bypass and required bypass valve count both follow simulated power.
// [R4] Power above setpoint removes low power bypass; active bypass is indicated.
// [R5] Charging header pressure bypass allowed only in Shutdown or Refuel.
// [R6] Operators use four per-division switches to bypass charging pressure trip.
// [R7] Bypass permits reset despite low header pressure; bypass is indicated.
// [R8] Each division sends rod withdrawal block while its charging bypass exists.
// [R9] Startup or Run cancels charging bypass regardless of switch positions.
// [R10] Alarm if any charging bypass switch left in bypass in Startup or Run.
// [R11] Isolation valve trip bypassed per division below pressure, not in Run; alarmed.
// [R12] Four line switches bypass closed isolation valve signals of one line; indicated.
// [R13] Bus loss trip bypassed outside Run and indicated.
// [R14] Shutdown position scram bypassed after about 10 s delay; alarmed.
// [R15] In Run startup monitor trips bypassed and rod blocks disabled; indicated only.
// [R16] In Run neutron monitor logic forced to coincident trip mode.
// [R17] Alarm if any selector is non-coincident while in Run.
// [R18] Non-coincident division trips on any single startup monitor trip.
// [R19] Water level high trip bypassed outside Run and indicated.
// [R20] Condenser pressure high trip bypassed outside Run and indicated.
// [R21] Moving the mode switch to Shutdown initiates a scram.
// [R22] Each trip output is its condition gated by inverse bypass, per division.
// [R23] Setpoints, valve time limit and valve counts are configurable registers.
`include "stb_params.svh"

module stb_scram_bypass #(
    parameter logic [31:0] SD_DELAY_CYCLES = 32'(`STB_SD_DELAY_CYCLES),
    parameter logic [31:0] TBV_LIMIT_CYCLES = 32'(`STB_TBV_LIMIT_CYCLES)
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // Plant inputs, asynchronous
    input wire logic [1:0] reactor_mode_in,
    input wire logic [7:0] simulated_power_in,
    input wire logic [47:0] reactor_pressure_in,
    input wire logic [3:0] turbine_stop_valve_trip_in,
    input wire logic [3:0] turbine_control_valve_trip_in,
    input wire logic [7:0] turbine_bypass_valve_open_in,
    input wire logic [3:0] charging_pressure_low_in,
    input wire logic [3:0] charging_bypass_switch_in,
    input wire logic [3:0] main_steam_isolation_valve_closed_in,
    input wire logic [3:0] main_steam_isolation_valve_line_switch_in,
    input wire logic [3:0] bus_loss_trip_in,
    input wire logic [3:0] level_high_trip_in,
    input wire logic [3:0] condenser_trip_in,
    input wire logic [3:0] startup_range_monitor_trip_in,
    input wire logic [3:0] startup_range_monitor_rod_block_in,
    input wire logic [3:0] noncoincident_select_in,
    // Gated trips per division
    output logic [3:0] turbine_valve_trip_out,
    output logic [3:0] charging_pressure_trip_out,
    output logic [3:0] main_steam_isolation_valve_trip_out,
    output logic [3:0] bus_loss_trip_out,
    output logic [3:0] level_high_trip_out,
    output logic [3:0] condenser_trip_out,
    output logic [3:0] startup_range_monitor_trip_out,
    output logic [3:0] startup_range_monitor_rod_block_out,
    output logic [3:0] shutdown_mode_scram_out,
    output logic [3:0] coincident_mode_out,
    output logic [3:0] rod_withdrawal_block_out,
    // Main control room indications and alarms
    output logic low_power_bypass_out,
    output logic bypass_valve_bypass_out,
    output logic [3:0] charging_bypass_out,
    output logic [3:0] isolation_auto_bypass_out,
    output logic [3:0] isolation_line_bypass_out,
    output logic mode_bypass_out,
    output logic shutdown_scram_bypass_out,
    output logic startup_range_monitor_bypass_out,
    output logic charging_switch_alarm_out,
    output logic isolation_bypass_alarm_out,
    output logic shutdown_bypass_alarm_out,
    output logic noncoincident_alarm_out
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYNC_W = 114;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    wire [SYNC_W-1:0] raw_in = {reactor_mode_in, simulated_power_in, reactor_pressure_in,
        turbine_stop_valve_trip_in, turbine_control_valve_trip_in, turbine_bypass_valve_open_in,
        charging_pressure_low_in, charging_bypass_switch_in, main_steam_isolation_valve_closed_in,
        main_steam_isolation_valve_line_switch_in, bus_loss_trip_in, level_high_trip_in,
        condenser_trip_in, startup_range_monitor_trip_in, startup_range_monitor_rod_block_in,
        noncoincident_select_in};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire [1:0] s_mode = sync_b[113:112];
    wire [7:0] s_power = sync_b[111:104];
    wire [47:0] s_pressure = sync_b[103:56];
    wire [3:0] s_tsv = sync_b[55:52];
    wire [3:0] s_tcv = sync_b[51:48];
    wire [7:0] s_tbv_open = sync_b[47:40];
    wire [3:0] s_chg_low = sync_b[39:36];
    wire [3:0] s_chg_sw = sync_b[35:32];
    wire [3:0] s_main_steam_isolation_valve_closed = sync_b[31:28];
    wire [3:0] s_main_steam_isolation_valve_line_sw = sync_b[27:24];
    wire [3:0] s_bus_loss = sync_b[23:20];
    wire [3:0] s_level_high = sync_b[19:16];
    wire [3:0] s_condenser = sync_b[15:12];
    wire [3:0] s_srm_trip = sync_b[11:8];
    wire [3:0] s_srm_block = sync_b[7:4];
    wire [3:0] s_noncoinc = sync_b[3:0];

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [7:0] power_sp;
    logic [11:0] pressure_sp;
    logic [31:0] tbv_limit;
    logic [3:0] cnt_lo;
    logic [3:0] cnt_hi;
    logic [7:0] cnt_split;

    // ****************************************
    // Mode decode
    // ****************************************
    wire mode_shutdown = (s_mode == stb_pkg::STB_MODE_SHUTDOWN);
    wire mode_refuel = (s_mode == stb_pkg::STB_MODE_REFUEL);
    wire mode_startup = (s_mode == stb_pkg::STB_MODE_STARTUP);
    wire mode_run = (s_mode == stb_pkg::STB_MODE_RUN);
    wire not_run = ~mode_run;

    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : count_ones

    // ****************************************
    // Turbine valve closure bypasses
    // ****************************************
    wire low_power = (s_power < power_sp); // [R1] [R3] [R4]
    wire [3:0] tbv_required = (s_power < cnt_split) ? cnt_lo : cnt_hi; // [R3]
    wire tbv_enough = (count_ones(s_tbv_open) >= tbv_required); // [R2]
    wire any_closure = |(s_tsv | s_tcv);
    logic closure_seen;
    logic [31:0] tbv_timer;
    logic tbv_bypass;
    // Window opens on first closure; late valves do not count
    wire tbv_in_window = any_closure && (!closure_seen || tbv_timer < tbv_limit);
    wire next_tbv_bypass = any_closure && (tbv_bypass || (tbv_in_window && tbv_enough)); // [R2]
    wire [31:0] next_tbv_timer = !any_closure ? 32'h0 :
        (closure_seen && tbv_timer != 32'hffffffff) ? tbv_timer + 32'h1 : tbv_timer;
    wire turbine_bypass = low_power | tbv_bypass;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            closure_seen <= 1'b0;
            tbv_timer <= 32'h0;
            tbv_bypass <= 1'b0;
        end else begin
            closure_seen <= any_closure;
            tbv_timer <= next_tbv_timer;
            tbv_bypass <= next_tbv_bypass;
        end
    end

    // ****************************************
    // Shutdown position scram and delayed bypass
    // ****************************************
    stb_pkg::stb_sd_state_t sd_state;
    stb_pkg::stb_sd_state_t next_sd_state;
    logic [31:0] sd_count;
    wire sd_done = (sd_count >= SD_DELAY_CYCLES - 32'h1);

    always_comb begin
        case (sd_state)
            stb_pkg::STB_SD_IDLE: begin
                next_sd_state = mode_shutdown ? stb_pkg::STB_SD_SCRAM : stb_pkg::STB_SD_IDLE; // [R21]
            end
            stb_pkg::STB_SD_SCRAM: begin
                next_sd_state = !mode_shutdown ? stb_pkg::STB_SD_IDLE :
                    (sd_done ? stb_pkg::STB_SD_BYPASS : stb_pkg::STB_SD_SCRAM); // [R14]
            end
            stb_pkg::STB_SD_BYPASS: begin
                next_sd_state = mode_shutdown ? stb_pkg::STB_SD_BYPASS : stb_pkg::STB_SD_IDLE;
            end
            default: begin
                next_sd_state = stb_pkg::STB_SD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sd_state <= stb_pkg::STB_SD_IDLE;
            sd_count <= 32'h0;
        end else begin
            sd_state <= next_sd_state;
            sd_count <= (sd_state == stb_pkg::STB_SD_SCRAM) ? sd_count + 32'h1 : 32'h0;
        end
    end

    // ****************************************
    // Per-division bypass and trip logic
    // ****************************************
    wire chg_allowed = mode_shutdown | mode_refuel; // [R5] [R9]
    wire [3:0] chg_bypass = s_chg_sw & {4{chg_allowed}}; // [R6] [R7]
    logic [3:0] main_steam_isolation_valve_auto;
    wire [3:0] main_steam_isolation_valve_line_trip = s_main_steam_isolation_valve_closed & ~s_main_steam_isolation_valve_line_sw; // [R12]
    logic [3:0] srm_div_trip;

    always_comb begin
        for (int d = 0; d < 4; d++) begin
            main_steam_isolation_valve_auto[d] = not_run && (s_pressure[d*12 +: 12] < pressure_sp); // [R11]
            // Coincident: two monitors; non-coincident: any one
            srm_div_trip[d] = (s_noncoinc[d] && not_run) ? |s_srm_trip :
                (count_ones({4'h0, s_srm_trip}) >= 4'h2); // [R18] [R16]
        end
    end

    wire [3:0] next_turbine_trip = (s_tsv | s_tcv) & ~{4{turbine_bypass}}; // [R22] [R1] [R2]
    wire [3:0] next_chg_trip = s_chg_low & ~chg_bypass; // [R22] [R7]
    wire [3:0] next_main_steam_isolation_valve_trip = {4{|main_steam_isolation_valve_line_trip}} & ~main_steam_isolation_valve_auto; // [R22] [R11]
    wire [3:0] next_bus_trip = s_bus_loss & {4{mode_run}}; // [R13] [R22]
    wire [3:0] next_level_trip = s_level_high & {4{mode_run}}; // [R19] [R22]
    wire [3:0] next_cond_trip = s_condenser & {4{mode_run}}; // [R20] [R22]
    wire [3:0] next_srm_trip = srm_div_trip & {4{not_run}}; // [R15] [R22]
    wire [3:0] next_srm_block = s_srm_block & {4{not_run}}; // [R15]
    wire [3:0] next_sd_scram = {4{sd_state == stb_pkg::STB_SD_SCRAM}}; // [R21] [R14]
    wire [3:0] next_coinc = {4{mode_run}} | ~s_noncoinc; // [R16]
    wire next_chg_alarm = |s_chg_sw && (mode_startup || mode_run); // [R10]
    wire next_nc_alarm = |s_noncoinc && mode_run; // [R17]

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            turbine_valve_trip_out <= 4'h0;
            charging_pressure_trip_out <= 4'h0;
            main_steam_isolation_valve_trip_out <= 4'h0;
            bus_loss_trip_out <= 4'h0;
            level_high_trip_out <= 4'h0;
            condenser_trip_out <= 4'h0;
            startup_range_monitor_trip_out <= 4'h0;
            startup_range_monitor_rod_block_out <= 4'h0;
            shutdown_mode_scram_out <= 4'h0;
            coincident_mode_out <= 4'hf;
            rod_withdrawal_block_out <= 4'h0;
            low_power_bypass_out <= 1'b0;
            bypass_valve_bypass_out <= 1'b0;
            charging_bypass_out <= 4'h0;
            isolation_auto_bypass_out <= 4'h0;
            isolation_line_bypass_out <= 4'h0;
            mode_bypass_out <= 1'b0;
            shutdown_scram_bypass_out <= 1'b0;
            startup_range_monitor_bypass_out <= 1'b0;
            charging_switch_alarm_out <= 1'b0;
            isolation_bypass_alarm_out <= 1'b0;
            shutdown_bypass_alarm_out <= 1'b0;
            noncoincident_alarm_out <= 1'b0;
        end else begin
            turbine_valve_trip_out <= next_turbine_trip;
            charging_pressure_trip_out <= next_chg_trip;
            main_steam_isolation_valve_trip_out <= next_main_steam_isolation_valve_trip;
            bus_loss_trip_out <= next_bus_trip;
            level_high_trip_out <= next_level_trip;
            condenser_trip_out <= next_cond_trip;
            startup_range_monitor_trip_out <= next_srm_trip;
            startup_range_monitor_rod_block_out <= next_srm_block;
            shutdown_mode_scram_out <= next_sd_scram;
            coincident_mode_out <= next_coinc;
            rod_withdrawal_block_out <= chg_bypass; // [R8]
            low_power_bypass_out <= low_power; // [R4]
            bypass_valve_bypass_out <= tbv_bypass;
            charging_bypass_out <= chg_bypass; // [R7]
            isolation_auto_bypass_out <= main_steam_isolation_valve_auto;
            isolation_line_bypass_out <= s_main_steam_isolation_valve_line_sw; // [R12]
            mode_bypass_out <= not_run; // [R13] [R19] [R20]
            shutdown_scram_bypass_out <= (sd_state == stb_pkg::STB_SD_BYPASS);
            startup_range_monitor_bypass_out <= mode_run; // [R15]
            charging_switch_alarm_out <= next_chg_alarm;
            isolation_bypass_alarm_out <= |main_steam_isolation_valve_auto; // [R11]
            shutdown_bypass_alarm_out <= (sd_state == stb_pkg::STB_SD_BYPASS); // [R14]
            noncoincident_alarm_out <= next_nc_alarm;
        end
    end

    // ****************************************
    // AHB-Lite register slave
    // ****************************************
    // Zero wait states; unmapped reads return zero, writes there are dropped
    logic wr_pend;
    logic [7:0] wr_addr;
    wire addr_take = hsel_in && htrans_in[1] && hready_in;
    wire [7:0] rd_ofs = {haddr_in[7:2], 2'b00};
    wire [31:0] ind_word = {14'h0, startup_range_monitor_bypass_out, shutdown_scram_bypass_out,
        mode_bypass_out, bypass_valve_bypass_out, low_power_bypass_out, isolation_line_bypass_out,
        isolation_auto_bypass_out, charging_bypass_out, 1'b0};
    wire [31:0] alarm_word = {28'h0, noncoincident_alarm_out, shutdown_bypass_alarm_out,
        isolation_bypass_alarm_out, charging_switch_alarm_out};
    wire [31:0] cfg_word = {16'h0, cnt_split, cnt_hi, cnt_lo};
    wire [31:0] rd_word =
        (rd_ofs == `STB_OFS_POWER_SP) ? {24'h0, power_sp} :
        (rd_ofs == `STB_OFS_PRESSURE_SP) ? {20'h0, pressure_sp} :
        (rd_ofs == `STB_OFS_TBV_LIMIT) ? tbv_limit :
        (rd_ofs == `STB_OFS_VALVE_CFG) ? cfg_word :
        (rd_ofs == `STB_OFS_INDICATION) ? ind_word :
        (rd_ofs == `STB_OFS_ALARM) ? alarm_word : 32'h0;
    wire [31:0] next_hrdata = (addr_take && !hwrite_in && haddr_in[31:8] == 24'h0) ? rd_word : 32'h0;

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hrdata_out <= 32'h0;
        end else begin
            wr_pend <= addr_take && hwrite_in && haddr_in[31:8] == 24'h0;
            wr_addr <= rd_ofs;
            hrdata_out <= next_hrdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_sp <= `STB_RST_POWER_SP;
            pressure_sp <= `STB_RST_PRESSURE_SP;
            tbv_limit <= TBV_LIMIT_CYCLES;
            cnt_lo <= `STB_RST_CNT_LO;
            cnt_hi <= `STB_RST_CNT_HI;
            cnt_split <= `STB_RST_CNT_SPLIT;
        end else if (wr_pend) begin
            if (wr_addr == `STB_OFS_POWER_SP) power_sp <= hwdata_in[7:0]; // [R23]
            if (wr_addr == `STB_OFS_PRESSURE_SP) pressure_sp <= hwdata_in[11:0]; // [R23]
            if (wr_addr == `STB_OFS_TBV_LIMIT) tbv_limit <= hwdata_in; // [R23]
            if (wr_addr == `STB_OFS_VALVE_CFG) begin
                cnt_lo <= hwdata_in[`STB_CFG_LO_LSB +: 4]; // [R23]
                cnt_hi <= hwdata_in[`STB_CFG_HI_LSB +: 4];
                cnt_split <= hwdata_in[`STB_CFG_SPLIT_LSB +: 8];
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    turbine_low_power_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
        low_power |=> turbine_valve_trip_out == 4'h0 && low_power_bypass_out)
        else $error("Turbine valve trip not bypassed at low power");
    turbine_full_power_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
        !low_power && !tbv_bypass |=> turbine_valve_trip_out == $past(s_tsv | s_tcv))
        else $error("Turbine valve trip not restored above setpoint");
    charging_mode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R9]
        (mode_startup || mode_run) |=> charging_bypass_out == 4'h0 && rod_withdrawal_block_out == 4'h0)
        else $error("Charging bypass active in Startup or Run");
    rod_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R8]
        ##1 rod_withdrawal_block_out == ($past(s_chg_sw) & {4{$past(chg_allowed)}}))
        else $error("Rod withdrawal block does not follow charging bypass");
    charging_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
        mode_run && |s_chg_sw |=> charging_switch_alarm_out)
        else $error("Charging switch alarm missing");
    isolation_run_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R11]
        mode_run |=> isolation_auto_bypass_out == 4'h0 && !isolation_bypass_alarm_out)
        else $error("Isolation valve bypass active in Run");
    run_trips_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
        mode_run && s_bus_loss[0] && s_level_high[1] |=> bus_loss_trip_out[0] && level_high_trip_out[1])
        else $error("Bus loss or level trip bypassed in Run");
    shutdown_scram_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R21]
        sd_state == stb_pkg::STB_SD_IDLE && mode_shutdown ##1 mode_shutdown |=> shutdown_mode_scram_out == 4'hf)
        else $error("Shutdown position did not scram");
    shutdown_bypass_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
        sd_state == stb_pkg::STB_SD_SCRAM && sd_done && mode_shutdown |=> ##1 shutdown_bypass_alarm_out)
        else $error("Shutdown scram bypass not raised after delay");
    coincident_run_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R16]
        mode_run |=> coincident_mode_out == 4'hf && startup_range_monitor_trip_out == 4'h0)
        else $error("Coincident mode not forced in Run");
    noncoinc_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R17]
        $rose(next_nc_alarm) |=> noncoincident_alarm_out)
        else $error("Non-coincident alarm missing in Run");

endmodule : stb_scram_bypass

// ### stb_plant_model.sv
// Plant side model: mode switch, operator switches, raw trips, simulated power
module stb_plant_model (
    input wire logic clk_in,
    input wire logic new_pulse,
    output logic [1:0] reactor_mode_in,
    output logic [7:0] simulated_power_in,
    output logic [3:0] charging_bypass_switch_in,
    output logic [3:0] noncoincident_select_in,
    output logic [3:0] charging_pressure_low_in,
    output logic [3:0] main_steam_isolation_valve_closed_in,
    output logic [3:0] main_steam_isolation_valve_line_switch_in,
    output logic [3:0] bus_loss_trip_in,
    output logic [3:0] level_high_trip_in,
    output logic [3:0] condenser_trip_in,
    output logic [3:0] startup_range_monitor_trip_in,
    output logic [3:0] startup_range_monitor_rod_block_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 91;
    // Levels move only on request, so the bench can let them settle
    task automatic roll();
        {bus_loss_trip_in, level_high_trip_in, condenser_trip_in, startup_range_monitor_trip_in,
         charging_pressure_low_in, startup_range_monitor_rod_block_in, main_steam_isolation_valve_closed_in,
         main_steam_isolation_valve_line_switch_in} <= $random(seed);
        reactor_mode_in <= 2'($random(seed));
        simulated_power_in <= 8'($random(seed));
        {charging_bypass_switch_in, noncoincident_select_in} <= 8'($random(seed));
    endtask : roll
    initial roll();
    always @(posedge clk_in) begin
        if (new_pulse) begin
            roll();
        end
    end
endmodule : stb_plant_model

// ### stb_scram_bypass_bench.sv
// Self-checking bench for the scram bypass interlock
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t %h %h", $time, a, b); end end
module stb_scram_bypass_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_n_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out, new_pulse, run;
    logic low_power_bypass_out, bypass_valve_bypass_out, mode_bypass_out, shutdown_scram_bypass_out;
    logic startup_range_monitor_bypass_out, charging_switch_alarm_out, isolation_bypass_alarm_out;
    logic shutdown_bypass_alarm_out, noncoincident_alarm_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [1:0] htrans_in, reactor_mode_in;
    logic [2:0] hsize_in;
    logic [7:0] simulated_power_in, turbine_bypass_valve_open_in, sp;
    logic [47:0] reactor_pressure_in;
    logic [3:0] turbine_stop_valve_trip_in, turbine_control_valve_trip_in, charging_pressure_low_in, cb, st;
    logic [3:0] charging_bypass_switch_in, main_steam_isolation_valve_closed_in, bus_loss_trip_in;
    logic [3:0] main_steam_isolation_valve_line_switch_in, level_high_trip_in, condenser_trip_in;
    logic [3:0] startup_range_monitor_trip_in, startup_range_monitor_rod_block_in, noncoincident_select_in;
    logic [3:0] turbine_valve_trip_out, charging_pressure_trip_out, main_steam_isolation_valve_trip_out;
    logic [3:0] bus_loss_trip_out, level_high_trip_out, condenser_trip_out, startup_range_monitor_trip_out;
    logic [3:0] startup_range_monitor_rod_block_out, shutdown_mode_scram_out, coincident_mode_out;
    logic [3:0] rod_withdrawal_block_out, charging_bypass_out, isolation_auto_bypass_out, isolation_line_bypass_out;
    logic [31:0] addrs [5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h100};
    logic [31:0] exps [5] = '{32'h28, 32'h100, 32'ha, 32'h4662, 32'h0};
    int n_fail = 0;
    int checks_done = 0;
    int seed = 91;
    stb_scram_bypass #(.SD_DELAY_CYCLES(32'd20), .TBV_LIMIT_CYCLES(32'd10)) dut_u (.*);
    stb_plant_model plant_u (.*);
    assign hready_in = hreadyout_out;
    task automatic wrap_up();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_ready();
        int n = 0;
        do begin @(posedge clk_in); n++; end while (hreadyout_out !== 1'b1 && n < 50);
        if (hreadyout_out !== 1'b1) begin n_fail++; wrap_up(); end
    endtask : wait_ready
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= w;
        wait_ready();
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_ready();
        rd = hrdata_out;
    endtask : ahb
    task automatic check_plant();
        run = (reactor_mode_in == 2'h3);
        cb = reactor_mode_in[1] ? 4'h0 : charging_bypass_switch_in;
        st = startup_range_monitor_trip_in;
        `CHK(mode_bypass_out, !run)
        `CHK(bus_loss_trip_out, run ? bus_loss_trip_in : 4'h0)
        `CHK(level_high_trip_out, run ? level_high_trip_in : 4'h0)
        `CHK(condenser_trip_out, run ? condenser_trip_in : 4'h0)
        `CHK(charging_bypass_out, cb)
        `CHK(rod_withdrawal_block_out, cb)
        `CHK(charging_pressure_trip_out, charging_pressure_low_in & ~cb)
        `CHK(charging_switch_alarm_out, reactor_mode_in[1] & |charging_bypass_switch_in)
        `CHK(startup_range_monitor_bypass_out, run)
        `CHK(startup_range_monitor_rod_block_out, run ? 4'h0 : startup_range_monitor_rod_block_in)
        `CHK(coincident_mode_out, run ? 4'hf : ~noncoincident_select_in)
        `CHK(noncoincident_alarm_out, run & |noncoincident_select_in)
        `CHK(startup_range_monitor_trip_out, run ? 4'h0 : ($countones(st) > 1 ? 4'hf : {4{|st}} & noncoincident_select_in))
        `CHK(low_power_bypass_out, simulated_power_in < sp)
        `CHK(turbine_valve_trip_out, turbine_stop_valve_trip_in & {4{simulated_power_in >= sp}})
        `CHK(isolation_line_bypass_out, main_steam_isolation_valve_line_switch_in)
        `CHK(isolation_bypass_alarm_out, !run)
        `CHK(main_steam_isolation_valve_trip_out, {4{run & |(main_steam_isolation_valve_closed_in & ~main_steam_isolation_valve_line_switch_in)}})
    endtask : check_plant
    task automatic run_plant(input int n);
        for (int i = 0; i < n; i++) begin
            new_pulse <= 1'b1;
            turbine_stop_valve_trip_in <= 4'($random(seed));
            @(posedge clk_in);
            new_pulse <= 1'b0;
            repeat (5) @(posedge clk_in);
            @(negedge clk_in);
            check_plant();
            @(posedge clk_in);
        end
    endtask : run_plant
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        {htrans_in, haddr_in, hwrite_in, hwdata_in, new_pulse, rst_n_in} = '0;
        {reactor_pressure_in, turbine_stop_valve_trip_in, turbine_control_valve_trip_in} = '0;
        turbine_bypass_valve_open_in = 8'h0;
        hsel_in = 1'b1;
        hsize_in = 3'h2;
        sp = 8'h28;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, addrs[i], 32'h0);
            `CHK(rd, exps[i])
        end
        run_plant(20);
        ahb(1'b1, 32'h0, 32'h50);
        sp = 8'h50;
        ahb(1'b0, 32'h0, 32'h0);
        `CHK(rd, 32'h50)
        run_plant(20);
        wrap_up();
    end
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule : stb_scram_bypass_bench
